// file: abc_pkg.sv
/*
 * Shared constants of the analog block converter control: register map,
 * field positions, reset values and timing counts.
 * Assumes a single 25 MHz system clock and an AXI4-Lite register master.
 */
// Functional notes
// - comparator powerdown of 1 stops the converter, digital logic keeps running
// - converter reset, active high, resets the converter and disables the quads
// - busy is 1 during a conversion; valid is 1 when the 12-bit result holds
// - calibrating is 1 during power-up and converter-reset calibration, otherwise 0
// - sampling is 1 only while an analog signal is being acquired
// - reference select 0 drives the internal 2.56 V reference out, 1 takes external
// - config port: 8-bit address, write and read data, own clock, write enable high
// - config port reset is active low; port held in reset while it is 0
// - ten active-high current monitor strobes, one per quad, each independent
package abc_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_TIMING  = 8'h04;
    localparam logic [7:0] OFS_STROBE  = 8'h08;
    localparam logic [7:0] OFS_STATUS  = 8'h0C;
    // register field positions, reset values and responses
    localparam int CTRL_START  = 0;
    localparam int CTRL_REFSEL = 1;
    localparam int CTRL_PWRDN  = 2;
    localparam int CTRL_CRST   = 3;
    localparam int CTRL_CHAN   = 4;
    localparam int CTRL_MODE   = 12;
    localparam int TIM_STC     = 8;
    localparam int STB_TEMP    = 16;
    localparam int STAT_RESULT = 16;
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
    localparam logic [31:0] TIMING_RESET = 32'h0000_0000;
    localparam logic [31:0] STROBE_RESET = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
    // config byte fields and quad count
    localparam int CFG_PRESC  = 0;
    localparam int CFG_MUX    = 3;
    localparam int CFG_DIRECT = 5;
    localparam int CFG_POLAR  = 6;
    localparam int QUADS      = 10;
    // timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int CAL_TIME_NS   = 4000;
    localparam logic [11:0] CAL_CYCLES = 12'((CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [8:0]  SAMPLE_EXTRA = 9'h002;
endpackage

// file: abc_converter.sv
/*
 * Conversion sequencer: calibration, sampling and bit conversion, with
 * the busy, calibrating, sampling and valid flags and the result word.
 * Assumes synchronous inputs from logic on the same clock; the analog
 * code is taken from the analog front end at the end of sampling.
 */
`timescale 1ns/1ps
module abc_converter (
    input  wire logic        mclk_in,
    input  wire logic        reset_in,
    input  wire logic        conv_reset_in,
    input  wire logic        powerdown_in,
    input  wire logic        start_in,
    input  wire logic [3:0]  mode_in,
    input  wire logic [7:0]  clock_divide_in,
    input  wire logic [7:0]  sample_time_in,
    input  wire logic [11:0] analog_code_in,
    output logic             busy_out,
    output logic             calibrating_out,
    output logic             sampling_out,
    output logic             result_valid_out,
    output logic [11:0]      result_out
);
    typedef enum logic [1:0] {ST_CAL, ST_IDLE, ST_SAMPLE, ST_CONV} abc_state_type;

    abc_state_type state_q, state_d;
    logic [11:0]   cnt_q, cnt_d;
    logic [7:0]    div_q, div_d;
    logic [11:0]   code_q, code_d;
    logic [11:0]   result_q, result_d;
    logic          valid_q, valid_d;
    logic          tick;
    logic [3:0]    bits;
    logic [3:0]    shift;

    // resolution from mode bits 1:0: 0 gives 10 bits, 1 gives 12 bits, else 8 bits
    always_comb begin
        case (mode_in[1:0])
            2'h0:    bits = 4'hA;
            2'h1:    bits = 4'hC;
            default: bits = 4'h8;
        endcase
        shift = 4'hC - bits;
    end

    assign tick = (div_q == clock_divide_in);

    // next state; powerdown freezes the sequencer, flags may then be stale
    always_comb begin
        state_d  = state_q;
        cnt_d    = cnt_q;
        div_d    = div_q;
        code_d   = code_q;
        result_d = result_q;
        valid_d  = valid_q;
        if (!powerdown_in) begin
            case (state_q)
                ST_CAL: begin
                    cnt_d = cnt_q + 12'h001;
                    if (cnt_q == abc_pkg::CAL_CYCLES - 12'h001) begin
                        state_d = ST_IDLE;
                        cnt_d   = 12'h000;
                    end
                end
                ST_IDLE: begin
                    if (start_in) begin
                        state_d = ST_SAMPLE;
                        cnt_d   = 12'h000;
                        div_d   = 8'h00;
                        valid_d = 1'b0;
                    end
                end
                ST_SAMPLE: begin
                    div_d = tick ? 8'h00 : div_q + 8'h01;
                    if (tick) begin
                        cnt_d = cnt_q + 12'h001;
                        if (cnt_q[8:0] == {1'b0, sample_time_in} + abc_pkg::SAMPLE_EXTRA - 9'h001) begin
                            code_d  = analog_code_in;
                            cnt_d   = 12'h000;
                            state_d = ST_CONV;
                        end
                    end
                end
                ST_CONV: begin
                    div_d = tick ? 8'h00 : div_q + 8'h01;
                    if (tick) begin
                        cnt_d = cnt_q + 12'h001;
                        if (cnt_q[3:0] == bits - 4'h1) begin
                            result_d = code_q >> shift;
                            valid_d  = 1'b1;
                            state_d  = ST_IDLE;
                        end
                    end
                end
                default: state_d = ST_CAL;
            endcase
        end
    end

    // either reset sends the converter back through calibration
    always_ff @(posedge mclk_in) begin
        if (reset_in || conv_reset_in) begin
            state_q  <= ST_CAL;
            cnt_q    <= 12'h000;
            div_q    <= 8'h00;
            code_q   <= 12'h000;
            result_q <= 12'h000;
            valid_q  <= 1'b0;
        end else begin
            state_q  <= state_d;
            cnt_q    <= cnt_d;
            div_q    <= div_d;
            code_q   <= code_d;
            result_q <= result_d;
            valid_q  <= valid_d;
        end
    end

    assign busy_out         = (state_q == ST_SAMPLE) || (state_q == ST_CONV);
    assign calibrating_out  = (state_q == ST_CAL);
    assign sampling_out     = (state_q == ST_SAMPLE);
    assign result_valid_out = valid_q;
    assign result_out       = result_q;

    start_busy_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        state_q == ST_IDLE && start_in && !powerdown_in && !conv_reset_in
        |=> busy_out && sampling_out && !result_valid_out)
        else $error("accepted start did not raise busy and sampling");
    sample_busy_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        sampling_out |-> busy_out && !calibrating_out)
        else $error("sampling flag outside a conversion");
    conv_reset_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        conv_reset_in |=> calibrating_out && !busy_out && !result_valid_out)
        else $error("converter reset did not clear the converter");
    power_hold_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        powerdown_in && !conv_reset_in |=> $stable(state_q) && $stable(result_q))
        else $error("converter moved while powered down");
    done_valid_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        $fell(busy_out) && !$past(conv_reset_in) && !$past(reset_in)
        |-> result_valid_out && !sampling_out)
        else $error("conversion ended without valid result");
    cal_end_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        $fell(calibrating_out) && !$past(conv_reset_in)
        |-> $past(cnt_q) == abc_pkg::CAL_CYCLES - 12'h001 && !busy_out)
        else $error("calibration ended at the wrong count");
endmodule

// file: abc_top.sv
/*
 * Analog block converter control top: AXI4-Lite register slave, quad
 * strobe gating, reference select, the byte-wide config port and the
 * per-channel config lookup feeding the analog input path.
 * Assumes config port pins arrive from another clock and are resynchronised;
 * the config clock must be slower than a quarter of the system clock.
 */
`timescale 1ns/1ps
module abc_top (
    input  wire logic        mclk_in,
    input  wire logic        reset_in,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // analog side
    input  wire logic [11:0] analog_code_in,
    output logic             quad_enable_out,
    output logic [9:0]       current_monitor_strobe_out,
    output logic [9:0]       temp_monitor_strobe_out,
    output logic             reference_pin_oe_out,
    output logic [4:0]       channel_number_out,
    output logic [2:0]       prescaler_code_out,
    output logic [1:0]       input_mux_select_out,
    output logic             direct_switch_out,
    output logic             polarity_out,
    // config port
    input  wire logic        config_port_clock_in,
    input  wire logic        config_port_reset_n_in,
    input  wire logic        config_write_enable_in,
    input  wire logic [7:0]  config_address_in,
    input  wire logic [7:0]  config_write_data_in,
    output logic [7:0]       config_read_data_out
);
    logic [31:0] ctrl_q, ctrl_d, timing_q, timing_d, strobe_q, strobe_d;
    logic [7:0]  awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0]  wstrb_q, wstrb_d;
    logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic        start_q, start_d;
    logic        busy, calibrating, sampling, valid;
    logic [11:0] result;

    // merge a bus word into a register under byte strobes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction

    // bus channel state; address and data may arrive in either order
    always_comb begin
        logic [7:0]  wa;
        logic [31:0] wd;
        logic [3:0]  ws;
        wa        = aw_have_q ? awaddr_q : s_axi_awaddr;
        wd        = w_have_q ? wdata_q : s_axi_wdata;
        ws        = w_have_q ? wstrb_q : s_axi_wstrb;
        awaddr_d  = awaddr_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        aw_have_d = aw_have_q || (s_axi_awvalid && s_axi_awready);
        w_have_d  = w_have_q || (s_axi_wvalid && s_axi_wready);
        bvalid_d  = bvalid_q && !s_axi_bready;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q && !s_axi_rready;
        rresp_d   = rresp_q;
        rdata_d   = rdata_q;
        ctrl_d    = ctrl_q;
        timing_d  = timing_q;
        strobe_d  = strobe_q;
        start_d   = 1'b0;
        if (s_axi_awvalid && s_axi_awready) awaddr_d = s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready) begin
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (aw_have_d && w_have_d) begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = abc_pkg::RESP_OKAY;
            case (wa)
                abc_pkg::OFS_CTRL: begin
                    ctrl_d  = merge(ctrl_q, wd, ws);
                    start_d = ws[0] && wd[abc_pkg::CTRL_START];
                    ctrl_d[abc_pkg::CTRL_START] = 1'b0;
                end
                abc_pkg::OFS_TIMING: timing_d = merge(timing_q, wd, ws);
                abc_pkg::OFS_STROBE: strobe_d = merge(strobe_q, wd, ws);
                abc_pkg::OFS_STATUS: ;
                default:             bresp_d = abc_pkg::RESP_SLVERR;
            endcase
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d  = abc_pkg::RESP_OKAY;
            case (s_axi_araddr)
                abc_pkg::OFS_CTRL:   rdata_d = ctrl_q;
                abc_pkg::OFS_TIMING: rdata_d = timing_q;
                abc_pkg::OFS_STROBE: rdata_d = strobe_q;
                abc_pkg::OFS_STATUS: begin
                    rdata_d = 32'h0000_0000;
                    rdata_d[3:0] = {valid, sampling, calibrating, busy};
                    rdata_d[abc_pkg::STAT_RESULT +: 12] = result;
                end
                default: begin
                    rdata_d = 32'h0000_0000;
                    rresp_d = abc_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            ctrl_q    <= abc_pkg::CTRL_RESET;
            timing_q  <= abc_pkg::TIMING_RESET;
            strobe_q  <= abc_pkg::STROBE_RESET;
            awaddr_q  <= 8'h00;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= 2'h0;
            rvalid_q  <= 1'b0;
            rresp_q   <= 2'h0;
            rdata_q   <= 32'h0000_0000;
            start_q   <= 1'b0;
        end else begin
            ctrl_q    <= ctrl_d;
            timing_q  <= timing_d;
            strobe_q  <= strobe_d;
            awaddr_q  <= awaddr_d;
            wdata_q   <= wdata_d;
            wstrb_q   <= wstrb_d;
            aw_have_q <= aw_have_d;
            w_have_q  <= w_have_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rresp_q   <= rresp_d;
            rdata_q   <= rdata_d;
            start_q   <= start_d;
        end
    end

    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready  = !w_have_q && !bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;

    abc_converter u_conv (
        .mclk_in          (mclk_in),
        .reset_in         (reset_in),
        .conv_reset_in    (ctrl_q[abc_pkg::CTRL_CRST]),
        .powerdown_in     (ctrl_q[abc_pkg::CTRL_PWRDN]),
        .start_in         (start_q),
        .mode_in          (ctrl_q[abc_pkg::CTRL_MODE +: 4]),
        .clock_divide_in  (timing_q[7:0]),
        .sample_time_in   (timing_q[abc_pkg::TIM_STC +: 8]),
        .analog_code_in   (analog_code_in),
        .busy_out         (busy),
        .calibrating_out  (calibrating),
        .sampling_out     (sampling),
        .result_valid_out (valid),
        .result_out       (result)
    );

    // quads are disabled while the converter reset bit is set
    assign quad_enable_out            = !ctrl_q[abc_pkg::CTRL_CRST];
    assign current_monitor_strobe_out = quad_enable_out ? strobe_q[9:0] : 10'h000;
    assign temp_monitor_strobe_out    = quad_enable_out ?
                                        strobe_q[abc_pkg::STB_TEMP +: 10] : 10'h000;
    assign reference_pin_oe_out       = !ctrl_q[abc_pkg::CTRL_REFSEL];
    assign channel_number_out         = ctrl_q[abc_pkg::CTRL_CHAN +: 5];

    // config pins cross from their own clock: two flops, then edge detect
    logic [18:0] cfg_s1_q, cfg_s2_q;
    logic        cfg_clk_prev_q;
    logic        cfg_edge, cfg_rst, cfg_we;
    logic [7:0]  cfg_addr, cfg_wdata;
    logic [7:0]  cfg_mem [0:255];
    logic [7:0]  cfg_rdata_q, cfg_rdata_d;
    logic [7:0]  chan_cfg;

    always_ff @(posedge mclk_in) begin
        cfg_s1_q       <= {config_port_clock_in, config_port_reset_n_in, config_write_enable_in,
                           config_address_in, config_write_data_in};
        cfg_s2_q       <= cfg_s1_q;
        cfg_clk_prev_q <= reset_in ? 1'b0 : cfg_s2_q[18];
    end

    assign cfg_edge  = cfg_s2_q[18] && !cfg_clk_prev_q;
    assign cfg_rst   = reset_in || !cfg_s2_q[17];
    assign cfg_we    = cfg_edge && cfg_s2_q[16];
    assign cfg_addr  = cfg_s2_q[15:8];
    assign cfg_wdata = cfg_s2_q[7:0];

    // one config byte per address
    for (genvar g = 0; g < 256; g++) begin : g_cfg
        always_ff @(posedge mclk_in) begin
            if (cfg_rst) begin
                cfg_mem[g] <= 8'h00;
            end else if (cfg_we && cfg_addr == 8'(g)) begin
                cfg_mem[g] <= cfg_wdata;
            end
        end
    end

    // read data follows the address on each config clock edge
    always_comb begin
        cfg_rdata_d = cfg_edge ? cfg_mem[cfg_addr] : cfg_rdata_q;
    end

    always_ff @(posedge mclk_in) begin
        cfg_rdata_q <= cfg_rst ? 8'h00 : cfg_rdata_d;
    end

    assign config_read_data_out = cfg_rdata_q;

    // the selected channel's config byte steers its analog input path
    assign chan_cfg             = cfg_mem[{3'h0, channel_number_out}];
    assign prescaler_code_out   = chan_cfg[abc_pkg::CFG_PRESC +: 3];
    assign input_mux_select_out = chan_cfg[abc_pkg::CFG_MUX +: 2];
    assign direct_switch_out    = chan_cfg[abc_pkg::CFG_DIRECT];
    assign polarity_out         = chan_cfg[abc_pkg::CFG_POLAR];

    cfg_write_a: assert property (@(posedge mclk_in) disable iff (cfg_rst)
        cfg_we |=> cfg_mem[$past(cfg_addr)] == $past(cfg_wdata))
        else $error("config write not stored");
    cfg_reset_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        !cfg_s2_q[17] |=> config_read_data_out == 8'h00 && cfg_mem[cfg_addr] == 8'h00)
        else $error("config port not held in reset");
    quad_gate_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        ctrl_q[abc_pkg::CTRL_CRST] |-> current_monitor_strobe_out == 10'h000
        && temp_monitor_strobe_out == 10'h000)
        else $error("quad strobes active during converter reset");
    ref_select_a: assert property (@(posedge mclk_in) disable iff (reset_in)
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && s_axi_awaddr == abc_pkg::OFS_CTRL && s_axi_wstrb[0]
        |=> reference_pin_oe_out == !$past(s_axi_wdata[1]))
        else $error("reference drive does not follow select");
endmodule

// file: abc_fabric_model.sv
/* fabric-side model: config port writer and the digitised analog code.
   assumes the bench calls put and hold_reset; config clock idles low */
`timescale 1ns/1ps
module abc_fabric_model (
    output logic        config_port_clock_in,
    output logic        config_port_reset_n_in,
    output logic        config_write_enable_in,
    output logic [7:0]  config_address_in,
    output logic [7:0]  config_write_data_in,
    output logic [11:0] analog_code_in
);
    // idle lines; the clock stands still between frames
    initial begin
        config_port_clock_in = 1'b0;
        config_port_reset_n_in = 1'b1;
        config_write_enable_in = 1'b0;
        config_address_in = 8'h00;
        config_write_data_in = 8'h00;
        analog_code_in = 12'hABC;
    end
    // one byte per slow frame, at least two and a half system clocks a phase
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        config_address_in = a;
        config_write_data_in = d;
        config_write_enable_in = 1'b1;
        #100 config_port_clock_in = 1'b1;
        #100 config_port_clock_in = 1'b0;
        config_write_enable_in = 1'b0;
        config_address_in = ~a; // released lines must not look valid
        config_write_data_in = ~d;
        #200;
    endtask
    task automatic hold_reset(input logic lvl);
        config_port_reset_n_in <= lvl;
    endtask
endmodule

// file: testbench.sv
/* self-checking bench for abc_top: axi-lite master tasks and scenarios.
   assumes abc_fabric_model drives the config port and analog code */
`timescale 1ns/1ps
module testbench;
    logic mclk_in = 0, reset_in = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, quad_enable_out, reference_pin_oe_out;
    logic direct_switch_out, polarity_out, config_port_clock_in, config_port_reset_n_in;
    logic config_write_enable_in;
    logic [1:0] s_axi_bresp, s_axi_rresp, input_mux_select_out, rs;
    logic [2:0] prescaler_code_out;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [4:0] channel_number_out;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, config_address_in;
    logic [7:0] config_write_data_in, config_read_data_out;
    logic [9:0] current_monitor_strobe_out, temp_monitor_strobe_out;
    logic [11:0] analog_code_in;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    int bad_count = 0, checks = 0;
    abc_top dut (.*);
    abc_fabric_model fab (.*);
    always #20 mclk_in = ~mclk_in;
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic final_report;
        if (bad_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // each valid and its payload stand until its ready is seen at a rising edge
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge mclk_in);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a);
        @(posedge mclk_in);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge mclk_in);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic t_reset;
        axr(abc_pkg::OFS_STATUS);
        chk("calibrating", 4'b0010, rd[3:0]);
        axr(abc_pkg::OFS_CTRL);
        chk("ctrl", abc_pkg::CTRL_RESET, rd);
        axr(abc_pkg::OFS_STROBE);
        chk("strobe", abc_pkg::STROBE_RESET, rd);
        chk("ref_oe", 1'b1, reference_pin_oe_out);
        axr(8'h10);
        chk("rresp_unmapped", 2'h2, rs);
        chk("rdata_unmapped", 32'h0, rd);
        axw(8'h10, 32'h0000_0001);
        chk("bresp_unmapped", 2'h2, rs);
        repeat (110) @(posedge mclk_in);
        axr(abc_pkg::OFS_STATUS);
        chk("idle", 4'b0000, rd[3:0]);
    endtask
    // long sample time so busy and sampling are both seen
    task automatic t_conv(input logic [3:0] m, input int sh);
        int n;
        axw(abc_pkg::OFS_TIMING, 32'h0000_0800);
        axw(abc_pkg::OFS_STROBE, 32'h0001_0000);
        chk("bresp", 2'h0, rs);
        axw(abc_pkg::OFS_CTRL, {16'h0, m, 12'h001});
        axr(abc_pkg::OFS_STATUS);
        chk("running", 3'b101, rd[2:0]);
        for (n = 0; n < 20 && rd[3] !== 1'b1; n++) axr(abc_pkg::OFS_STATUS);
        chk("done", 4'b1000, rd[3:0]);
        chk("result", 12'hABC >> sh, rd[27:16]);
        chk("tm_hold", 10'h001, temp_monitor_strobe_out);
    endtask
    task automatic t_power_reset;
        axw(abc_pkg::OFS_CTRL, 32'h5);
        axr(abc_pkg::OFS_STATUS);
        chk("pwrdn", 4'b1000, rd[3:0]);
        axw(abc_pkg::OFS_STROBE, 32'h02AA_0155);
        chk("cm", 10'h155, current_monitor_strobe_out);
        chk("tm", 10'h2AA, temp_monitor_strobe_out);
        axw(abc_pkg::OFS_CTRL, 32'h8);
        chk("quads", 11'h0, {quad_enable_out, current_monitor_strobe_out});
        axr(abc_pkg::OFS_STATUS);
        chk("crst", 4'b0010, rd[3:0]);
        axw(abc_pkg::OFS_CTRL, 32'h2);
        chk("ext_ref", 1'b0, reference_pin_oe_out);
    endtask
    task automatic t_config;
        fab.put(8'h03, 8'h2A);
        // read data shows the byte held before the edge's own write
        fab.put(8'h03, 8'h2A);
        axw(abc_pkg::OFS_CTRL, 32'h30);
        chk("chan", 5'h03, channel_number_out);
        chk("presc", 3'h2, prescaler_code_out);
        chk("mux", 2'h1, input_mux_select_out);
        chk("path", 2'b10, {direct_switch_out, polarity_out});
        chk("cfg_rd", 8'h2A, config_read_data_out);
        fab.hold_reset(1'b0);
        repeat (6) @(posedge mclk_in);
        chk("cfg_clr", 11'h0, {config_read_data_out, prescaler_code_out});
        fab.hold_reset(1'b1);
    endtask
    // watchdog well beyond the expected few hundred cycles
    initial begin
        repeat (20000) @(posedge mclk_in);
        bad_count++;
        final_report();
    end
    // main sequence
    initial begin
        repeat (5) @(posedge mclk_in);
        reset_in <= 1'b0;
        t_reset();
        t_conv(4'h0, 2);
        t_conv(4'h1, 0);
        t_conv(4'h2, 4);
        t_power_reset();
        t_config();
        final_report();
    end
endmodule
